// ### port_err_fsm.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module port_err_fsm
    import port_err_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic uf_rx,
    input wire logic uf_stored,
    input wire logic bist_far_rx,
    input wire logic bist_act,
    input wire logic esc_rx,
    input wire logic [1:0] esc_kind,
    input wire logic rerr_rx,
    input wire logic rerr_data,
    input wire logic crc_err_rx,
    input wire logic crc_data,
    input wire logic sdb_err_rx,
    input wire logic [DATA_W-1:0] sdb_active,
    input wire logic reg_err_rx,
    input wire logic dma_setup_rx,
    input wire logic other_d2h_rx,
    input wire logic slot_active,
    input wire logic ovf_rx,
    input wire logic unf_rx,
    input wire logic bad_pmp_rx,
    input wire logic pio_i_fail,
    input wire logic single_dev,
    input wire logic [3:0] fail_dev_in,
    input wire logic tf_bsy_set,
    input wire logic tf_drq_set,
    input wire logic [DATA_W-1:0] cmd_done,
    output logic uf_store_req,
    output logic port_irq,
    output logic frame_post_en,
    output logic frame_drop,
    output logic byte_count_upd,
    output logic command_list_running
);
    typedef struct packed {
        state_t st;
        logic [CTL_W-1:0] ctrl;
        logic [3:0] link_detect_state;
        logic cr;
        logic tf_bsy;
        logic tf_drq;
        logic p_bsy;
        logic p_drq;
        logic irq;
        logic [3:0] failing_device_field;
        logic [DATA_W-1:0] queued_active_register;
        logic [DATA_W-1:0] command_issue_bits;
    } fsm_t;

    fsm_t cur_ff;
    fsm_t nxt_ff;
    reg_bus_if rb ();
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic glob_bit;
    logic glob_set;
    logic glob_clr;
    logic run;
    logic fbs;
    logic idle;
    logic ci_hold;
    logic fatal_ev;
    logic nonfatal_ev;
    logic [DATA_W-1:0] port_word;

    apb_front u_front (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rb(rb.front)
    );

    sticky_bits #(.W(NUM_FLAGS)) u_flags (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(flag_set),
        .clr(flag_clr),
        .q(flags)
    );

    sticky_bits #(.W(1)) u_glob (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .set(glob_set),
        .clr(glob_clr),
        .q(glob_bit)
    );

    assign run = cur_ff.ctrl[CTL_RUN];
    assign fbs = cur_ff.ctrl[CTL_FBS];
    assign idle = (cur_ff.st == ST_IDLE) || (cur_ff.st == ST_SW_IDLE);
    assign flag_clr = (rb.wr && rb.addr == OFS_STATUS) ? rb.wdata[NUM_FLAGS-1:0] : '0;
    assign glob_clr = rb.wr && (rb.addr == OFS_GLOBAL) && rb.wdata[0];
    // Escape states keep every issued command visible to software
    assign ci_hold = cur_ff.st inside {ST_ESC, ST_ESC_SW, ST_FATAL};

    always_comb begin
        port_word = '0;
        port_word[PS_DET_LSB +: 4] = cur_ff.link_detect_state;
        port_word[PS_CR] = cur_ff.cr;
        port_word[PS_TF_BSY] = cur_ff.tf_bsy;
        port_word[PS_TF_DRQ] = cur_ff.tf_drq;
        port_word[PS_P_BSY] = cur_ff.p_bsy;
        port_word[PS_P_DRQ] = cur_ff.p_drq;
        port_word[PS_DEV_LSB +: 4] = cur_ff.failing_device_field;
    end

    always_comb begin
        nxt_ff = cur_ff;
        flag_set = '0;
        glob_set = 1'b0;
        fatal_ev = 1'b0;
        nonfatal_ev = 1'b0;
        rb.hit = 1'b1;
        rb.rdata = '0;
        case (rb.addr)
            OFS_CTRL: rb.rdata[CTL_W-1:0] = cur_ff.ctrl;
            OFS_STATUS: rb.rdata[NUM_FLAGS-1:0] = flags;
            OFS_GLOBAL: rb.rdata[0] = glob_bit;
            OFS_PORT: rb.rdata = port_word;
            OFS_QACT: rb.rdata = cur_ff.queued_active_register;
            OFS_CI: rb.rdata = cur_ff.command_issue_bits;
            default: rb.hit = 1'b0;
        endcase
        if (rb.wr && rb.addr == OFS_CTRL) begin
            nxt_ff.ctrl = rb.wdata[CTL_W-1:0];
        end
        if (!ci_hold) begin
            nxt_ff.command_issue_bits = cur_ff.command_issue_bits & ~cmd_done;
        end
        if (rb.wr && rb.addr == OFS_CI) begin
            nxt_ff.command_issue_bits = nxt_ff.command_issue_bits | rb.wdata;
        end
        nxt_ff.tf_bsy = cur_ff.tf_bsy | tf_bsy_set;
        nxt_ff.p_bsy = cur_ff.p_bsy | tf_bsy_set;
        nxt_ff.tf_drq = cur_ff.tf_drq | tf_drq_set;
        nxt_ff.p_drq = cur_ff.p_drq | tf_drq_set;
        // Error table, applied whenever the event is reported
        if (esc_rx && (esc_kind != FK_H2D_REG || !fbs)) begin
            flag_set[ST_IFS] = 1'b1;
        end
        if (esc_rx && esc_kind == FK_H2D_REG && fbs) begin
            flag_set[ST_INFS] = 1'b1;
            flag_set[ST_SDE] = 1'b1;
            nxt_ff.failing_device_field = fail_dev_in;
        end
        if (rerr_rx && rerr_data && !fbs) begin
            flag_set[ST_IFS] = 1'b1;
            fatal_ev = 1'b1;
        end
        if (rerr_rx && !rerr_data) begin
            flag_set[ST_INFS] = 1'b1;
            nonfatal_ev = 1'b1;
        end
        if (crc_err_rx) begin
            flag_set[crc_data ? ST_IFS : ST_INFS] = 1'b1;
            fatal_ev = fatal_ev | crc_data;
            nonfatal_ev = nonfatal_ev | !crc_data;
        end
        if (sdb_err_rx) begin
            nxt_ff.queued_active_register = sdb_active;
        end
        if (sdb_err_rx || reg_err_rx) begin
            flag_set[ST_TFES] = 1'b1;
            flag_set[ST_SDE] = flag_set[ST_SDE] | fbs;
            if (fbs) begin
                nxt_ff.failing_device_field = fail_dev_in;
            end
        end
        if (dma_setup_rx && !slot_active) begin
            flag_set[ST_IFS] = 1'b1;
            fatal_ev = 1'b1;
        end
        if (ovf_rx) begin
            flag_set[ST_OFS] = 1'b1;
            flag_set[ST_SDE] = flag_set[ST_SDE] | fbs;
            if (fbs) begin
                nxt_ff.failing_device_field = fail_dev_in;
            end
        end
        case (cur_ff.st)
            ST_IDLE, ST_SW_IDLE: begin
                nxt_ff.st = fbs ? ST_SW_IDLE : ST_IDLE;
                // First matching condition wins
                if (bist_far_rx) begin
                    nxt_ff.st = ST_FAR_LOOP;
                end else if (bist_act) begin
                    nxt_ff.st = ST_TEST;
                end else if (esc_rx && esc_kind == FK_H2D_REG && fbs) begin
                    nxt_ff.st = ST_ESC_SW;
                end else if (esc_rx && esc_kind != FK_D2H) begin
                    nxt_ff.st = ST_ESC;
                end else if ((esc_rx && esc_kind == FK_D2H) || fatal_ev) begin
                    nxt_ff.st = ST_FATAL;
                end else if (bad_pmp_rx) begin
                    nxt_ff.st = ST_BAD_PMP;
                end else if (uf_rx) begin
                    nxt_ff.st = ST_UF_STORE;
                end else if (nonfatal_ev) begin
                    nxt_ff.st = ST_NONFATAL;
                end
            end
            ST_UF_STORE: begin
                // Flag only after the copy to memory has finished
                if (uf_stored) begin
                    flag_set[ST_UFS] = 1'b1;
                    if (cur_ff.ctrl[CTL_UFE]) begin
                        nxt_ff.st = ST_UF_STATUS;
                    end else begin
                        nxt_ff.st = fbs ? ST_SW_IDLE : ST_IDLE;
                    end
                end
            end
            ST_UF_STATUS: begin
                glob_set = 1'b1;
                if (cur_ff.ctrl[CTL_GIE]) begin
                    nxt_ff.st = ST_UF_RAISE;
                end else begin
                    nxt_ff.st = fbs ? ST_SW_IDLE : ST_IDLE;
                end
            end
            ST_UF_RAISE: begin
                nxt_ff.irq = 1'b1;
                nxt_ff.st = fbs ? ST_SW_IDLE : ST_IDLE;
            end
            ST_FAR_LOOP: begin
                nxt_ff.link_detect_state = DET_FAR_LOOP;
                nxt_ff.st = ST_TEST;
            end
            ST_TEST: begin
                if (!run) begin
                    nxt_ff.st = ST_IDLE;
                end
            end
            ST_BAD_PMP: begin
                flag_set[ST_IPMS] = 1'b1;
                nxt_ff.st = ST_NONFATAL;
            end
            ST_NONFATAL: begin
                nxt_ff.st = fbs ? ST_SW_IDLE : ST_IDLE;
            end
            ST_ESC: begin
                nxt_ff.tf_bsy = 1'b0;
                nxt_ff.tf_drq = 1'b0;
                nxt_ff.p_bsy = 1'b0;
                nxt_ff.p_drq = 1'b0;
                flag_set[ST_IFS] = 1'b1;
                nxt_ff.st = ST_FATAL;
            end
            ST_ESC_SW: begin
                flag_set[ST_INFS] = 1'b1;
                nxt_ff.st = ST_ONE_DEV;
            end
            ST_FATAL: begin
                flag_set[ST_IFS] = 1'b1;
                flag_set[ST_PSS] = pio_i_fail;
                if (fbs && single_dev) begin
                    nxt_ff.st = ST_ONE_DEV;
                end else begin
                    nxt_ff.st = ST_WAIT_CLR;
                end
            end
            ST_WAIT_CLR: begin
                // Only software clearing run ends this wait; a fatal stop with fbs and single_dev skips it via ST_ONE_DEV
                if (!run) begin
                    nxt_ff.st = ST_IDLE;
                end
            end
            ST_ONE_DEV: begin
                nxt_ff.st = ST_SW_IDLE;
            end
            default: begin
                nxt_ff.st = ST_IDLE;
            end
        endcase
        // Withdrawn only once software has cleared the global bit
        if (cur_ff.irq && !glob_bit) begin
            nxt_ff.irq = 1'b0;
        end
        // Dropped early on a fatal stop that waits in ST_WAIT_CLR, always dropped with run low
        nxt_ff.cr = run && (cur_ff.st != ST_WAIT_CLR);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '{st: ST_IDLE, ctrl: CTRL_RESET, link_detect_state: DET_RESET,
                        failing_device_field: DEV_RESET, default: '0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign uf_store_req = (cur_ff.st == ST_UF_STORE);
    assign port_irq = cur_ff.irq;
    // Posting carries on after data errors until run is cleared
    assign frame_post_en = run && (cur_ff.st != ST_TEST);
    assign frame_drop = other_d2h_rx && !slot_active;
    assign byte_count_upd = unf_rx;
    assign command_list_running = cur_ff.cr;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    far_loop_det_a: assert property ((cur_ff.st == ST_FAR_LOOP) |=>
        (cur_ff.st == ST_TEST && cur_ff.link_detect_state == DET_FAR_LOOP))
        else $error("far loopback did not set detect and enter test");
    test_hold_a: assert property ((cur_ff.st == ST_TEST && run) |=>
        (cur_ff.st == ST_TEST))
        else $error("test state left while running");
    test_exit_a: assert property ((cur_ff.st == ST_TEST && !run) |=>
        (cur_ff.st == ST_IDLE))
        else $error("test state not left after run cleared");
    irq_hold_a: assert property ((port_irq && glob_bit) |=> port_irq)
        else $error("interrupt withdrawn before software cleared it");
    uf_order_a: assert property ($rose(flags[ST_UFS]) |->
        ($past(cur_ff.st) == ST_UF_STORE && $past(uf_stored)))
        else $error("unknown frame flag set before store finished");
    raise_exit_a: assert property ((cur_ff.st == ST_UF_RAISE) |=>
        (port_irq && cur_ff.st == (fbs ? ST_SW_IDLE : ST_IDLE)))
        else $error("raise state exit wrong");
    esc_clear_a: assert property ((cur_ff.st == ST_ESC) |=>
        (!cur_ff.tf_bsy && !cur_ff.p_drq && flags[ST_IFS] && cur_ff.st == ST_FATAL))
        else $error("escape did not clear taskfile and go fatal");
    ci_keep_a: assert property ((ci_hold && !(rb.wr && rb.addr == OFS_CI)) |=>
        $stable(cur_ff.command_issue_bits))
        else $error("command issue bits changed after escape");
    cr_clear_a: assert property ((!run) |=> !command_list_running)
        else $error("command running still set with run clear");
    dma_ifs_a: assert property ((dma_setup_rx && !slot_active) |=> flags[ST_IFS])
        else $error("slotless DMA setup did not set fatal flag");
    fatal_path_a: assert property ((cur_ff.st == ST_FATAL && !(fbs && single_dev)) |=>
        (cur_ff.st == ST_WAIT_CLR) ##1 (cur_ff.st == ST_WAIT_CLR || !$past(run)))
        else $error("fatal state did not wait for run clear");
endmodule // port_err_fsm
`default_nettype wire

// ### port_err_pkg.sv
package port_err_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_FLAGS = 8;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PORT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_QACT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CI = 8'h14;

    // Control register bits
    localparam int CTL_RUN = 0;
    localparam int CTL_FBS = 1;
    localparam int CTL_GIE = 2;
    localparam int CTL_UFE = 3;
    localparam int CTL_W = 4;
    localparam logic [CTL_W-1:0] CTRL_RESET = 4'h0;

    // Status flag bits, write one to clear
    localparam int ST_UFS = 0;
    localparam int ST_IFS = 1;
    localparam int ST_INFS = 2;
    localparam int ST_TFES = 3;
    localparam int ST_OFS = 4;
    localparam int ST_IPMS = 5;
    localparam int ST_PSS = 6;
    localparam int ST_SDE = 7;

    // Port state register fields
    localparam int PS_DET_LSB = 0;
    localparam int PS_CR = 4;
    localparam int PS_TF_BSY = 5;
    localparam int PS_TF_DRQ = 6;
    localparam int PS_P_BSY = 7;
    localparam int PS_P_DRQ = 8;
    localparam int PS_DEV_LSB = 12;

    localparam logic [3:0] DET_FAR_LOOP = 4'h4;
    localparam logic [3:0] DET_RESET = 4'h0;
    localparam logic [3:0] DEV_RESET = 4'h0;

    typedef enum logic [1:0] {
        FK_D2H = 2'h0,
        FK_H2D_DATA = 2'h1,
        FK_H2D_REG = 2'h2
    } frame_kind_t;

    typedef enum logic [14:0] {
        ST_IDLE = 15'h0001,
        ST_SW_IDLE = 15'h0002,
        ST_UF_STORE = 15'h0004,
        ST_UF_STATUS = 15'h0008,
        ST_UF_RAISE = 15'h0010,
        ST_FAR_LOOP = 15'h0020,
        ST_TEST = 15'h0040,
        ST_BAD_PMP = 15'h0080,
        ST_NONFATAL = 15'h0100,
        ST_ESC = 15'h0200,
        ST_ESC_SW = 15'h0400,
        ST_FATAL = 15'h0800,
        ST_WAIT_CLR = 15'h1000,
        ST_ONE_DEV = 15'h2000
    } state_t;
endpackage

// ### reg_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
    import port_err_pkg::*;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic hit;
    modport front(output wr, output addr, output wdata, input rdata, input hit);
    modport regs(input wr, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ### sticky_bits.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_bits #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] q;
    } bits_t;
    bits_t cur_ff;
    bits_t nxt_ff;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.q = (cur_ff.q & ~clr) | set;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign q = cur_ff.q;

    set_wins_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (set != '0) |=> ((q & $past(set)) == $past(set)))
        else $error("sticky bit lost a set");
endmodule // sticky_bits
`default_nettype wire

// ### apb_front.sv
`timescale 1ns/1ps
`default_nettype none
module apb_front
    import port_err_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    reg_bus_if.front rb
);
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic err;
    } front_t;
    front_t cur_ff;
    front_t nxt_ff;

    // Read data and error are captured in the setup cycle, so the access
    // phase always completes with no wait state
    always_comb begin
        nxt_ff = cur_ff;
        if (psel && !penable) begin
            nxt_ff.rdata = pwrite ? '0 : rb.rdata;
            nxt_ff.err = !rb.hit;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign rb.addr = paddr;
    assign rb.wdata = pwdata;
    assign rb.wr = psel && penable && pwrite && rb.hit;
    assign prdata = cur_ff.rdata;
    assign pslverr = psel && penable && cur_ff.err;
    assign pready = 1'b1;
endmodule // apb_front
`default_nettype wire

// ### dev_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module dev_link_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [3:0] sel,
    output logic [15:0] ev
);
    // One frame event per request, a single cycle wide, as the link layer reports it
    initial ev = 16'h0000;
    always @(posedge ref_clk) begin
        ev <= go ? (16'h0001 << sel) : 16'h0000;
    end
endmodule // dev_link_model
`default_nettype wire

// ### sata_port_error_event_fsm_test.sv
`timescale 1ns/1ps
`default_nettype none
module sata_port_error_event_fsm_test;
    import port_err_pkg::*;
    typedef struct packed {
        logic [3:0] ev;
        logic fbs;
        logic [1:0] kind;
        logic [7:0] exp;
        logic [7:0] msk;
    } row_t;
    logic ref_clk, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, slv, go = 1'b0, uf_store_req, port_irq, frame_post_en;
    logic [3:0] sel = 4'h0;
    logic [15:0] ev;
    logic [1:0] esc_kind = 2'h0;
    logic rerr_data = 1'b0, crc_data = 1'b0, slot_active = 1'b1, pio_i_fail = 1'b0;
    logic command_list_running, frame_drop, byte_count_upd;
    int fails = 0, cmp_count = 0, drops = 0, unfs = 0;
    row_t rows [16] = '{
        '{4'h6, 1'b0, 2'h0, 8'h04, 8'hFF}, '{4'h6, 1'b0, 2'h1, 8'h02, 8'hFF},
        '{4'h5, 1'b0, 2'h0, 8'h04, 8'hFF}, '{4'h5, 1'b0, 2'h1, 8'h02, 8'hFF},
        '{4'h7, 1'b0, 2'h0, 8'h08, 8'hFF}, '{4'h7, 1'b1, 2'h0, 8'h88, 8'hFF},
        '{4'h8, 1'b1, 2'h0, 8'h88, 8'hFF}, '{4'h9, 1'b0, 2'h0, 8'h02, 8'hFF},
        '{4'hB, 1'b0, 2'h0, 8'h10, 8'hFF}, '{4'hB, 1'b1, 2'h0, 8'h90, 8'hFF},
        '{4'hD, 1'b0, 2'h0, 8'h20, 8'h20}, '{4'h4, 1'b0, 2'h0, 8'h02, 8'hFF},
        '{4'h4, 1'b1, 2'h2, 8'h84, 8'hFF}, '{4'h4, 1'b0, 2'h2, 8'h02, 8'hFF},
        '{4'hA, 1'b0, 2'h0, 8'h00, 8'hFF}, '{4'hC, 1'b0, 2'h0, 8'h00, 8'hFF}};

    dev_link_model u_dev_link_model (.ref_clk(ref_clk), .go(go), .sel(sel), .ev(ev));
    port_err_fsm u_port_err_fsm (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .uf_rx(ev[0]), .uf_stored(ev[1]),
        .bist_far_rx(ev[2]), .bist_act(ev[3]), .esc_rx(ev[4]), .esc_kind(esc_kind),
        .rerr_rx(ev[5]), .rerr_data(rerr_data), .crc_err_rx(ev[6]), .crc_data(crc_data),
        .sdb_err_rx(ev[7]), .sdb_active(32'h0000_0003), .reg_err_rx(ev[8]),
        .dma_setup_rx(ev[9]), .other_d2h_rx(ev[10]), .slot_active(slot_active),
        .ovf_rx(ev[11]), .unf_rx(ev[12]), .bad_pmp_rx(ev[13]), .pio_i_fail(pio_i_fail),
        .single_dev(1'b0), .fail_dev_in(4'h3), .tf_bsy_set(ev[14]), .tf_drq_set(ev[15]),
        .cmd_done(32'h0000_0000), .uf_store_req(uf_store_req), .port_irq(port_irq),
        .frame_post_en(frame_post_en), .frame_drop(frame_drop),
        .byte_count_upd(byte_count_upd),
        .command_list_running(command_list_running));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Both outputs are one-cycle pulses, so they are counted rather than sampled
    always @(posedge ref_clk) begin
        if (frame_drop === 1'b1) drops++;
        if (byte_count_upd === 1'b1) unfs++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Release is left standing for one cycle by the leading edge wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fire(input logic [3:0] s);
        @(posedge ref_clk);
        go <= 1'b1;
        sel <= s;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, OFS_CTRL, {30'h0, rows[i].fbs, 1'b1});
            esc_kind <= rows[i].kind;
            rerr_data <= rows[i].kind[0];
            crc_data <= rows[i].kind[0];
            slot_active <= !(rows[i].ev inside {4'h9, 4'hA});
            fire(rows[i].ev);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(rd & rows[i].msk, rows[i].exp);
            apb(1'b1, OFS_CTRL, 32'h0);
            apb(1'b1, OFS_STATUS, 32'h0000_00FF);
        end
        slot_active <= 1'b1;
        chk(drops, 32'h1);
        chk(unfs, 32'h1);
        apb(1'b0, OFS_PORT, 32'h0);
        chk(rd[15:12], 32'h3);
        apb(1'b0, 8'h18, 32'h0);
        chk(slv, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0000_000F);
        fire(4'h0);
        chk(uf_store_req, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        fire(4'h1);
        chk(port_irq, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h0000_00FF);
        repeat (30) @(posedge ref_clk);
        chk(port_irq, 1'b1);
        apb(1'b0, OFS_GLOBAL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, OFS_GLOBAL, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
        chk(port_irq, 1'b0);
        for (int k = 2; k < 4; k++) begin
            apb(1'b1, OFS_CTRL, 32'h0000_0001);
            fire(k[3:0]);
            chk(frame_post_en, 1'b0);
            apb(1'b1, OFS_CTRL, 32'h0);
            apb(1'b1, OFS_CTRL, 32'h0000_0001);
            repeat (2) @(posedge ref_clk);
            chk(frame_post_en, 1'b1);
        end
        apb(1'b0, OFS_PORT, 32'h0);
        chk(rd[3:0], DET_FAR_LOOP);
        apb(1'b1, OFS_CI, 32'h0000_0001);
        fire(4'hE);
        apb(1'b0, OFS_PORT, 32'h0);
        chk(rd[PS_TF_BSY], 1'b1);
        pio_i_fail <= 1'b1;
        esc_kind <= 2'h1;
        fire(4'h4);
        apb(1'b0, OFS_PORT, 32'h0);
        chk(rd[8:4], 5'h00);
        apb(1'b0, OFS_CI, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h42);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        chk(command_list_running, 1'b1);
        // Mid-run reset must drop the running indication and the control word
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(command_list_running, 1'b0);
        chk(port_irq, 1'b0);
        resetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        stop_test();
    end
endmodule // sata_port_error_event_fsm_test
`default_nettype wire
